// ===== adc_host_pkg.sv
/*
  shared constants, pin and sample carriers for the converter host sequencer.
  assumes a 200 MHz system clock; every delay is a whole number of its cycles.
*/
package adc_host_pkg;

  localparam longint unsigned CLK_PS = 64'd5000;
  localparam longint unsigned PS_NS  = 64'd1000;
  localparam longint unsigned PS_US  = 64'd1000000;
  localparam longint unsigned PS_MS  = 64'd1000000000;

  // least times round up, never below one cycle
  function automatic int unsigned cyc_up(input longint unsigned t_ps);
    longint unsigned c;
    c = (t_ps + CLK_PS - 64'd1) / CLK_PS;                             // R16
    if (c == 64'h0) c = 64'h1;
    return c[31:0];
  endfunction : cyc_up

  // printed figures
  localparam int unsigned T_CNCS_NS   = 10;
  localparam int unsigned T_CSBSY_NS  = 40;
  localparam int unsigned T_BSYCS_NS  = 0;
  localparam int unsigned T_CSCN_NS   = 10;
  localparam int unsigned T_CSRD_NS   = 0;
  localparam int unsigned T_RDCS_NS   = 0;
  localparam int unsigned T_RD_HI_NS  = 15;
  localparam int unsigned T_RDDB_NS   = 17;
  localparam int unsigned T_SCLK_NS   = 50;
  localparam int unsigned T_CSCK_NS   = 8;
  localparam int unsigned T_CKCS_NS   = 10;
  localparam int unsigned T_OS_NS     = 20;
  localparam int unsigned T_CN_PL_NS  = 25;
  localparam int unsigned T_RST_HI_NS = 50;
  localparam int unsigned T_STANDBY_CTRL_N_US   = 100;
  localparam int unsigned T_RSTCN_US  = 25;
  localparam int unsigned T_SD_INT_MS = 50;
  localparam int unsigned T_SD_EXT_MS = 13;

  // cycle counts; rd low also covers the 17 ns data access
  localparam int unsigned CYC_CNCS   = cyc_up(longint'(T_CNCS_NS) * PS_NS);
  localparam int unsigned CYC_CSBSY  = cyc_up(longint'(T_CSBSY_NS) * PS_NS);
  localparam int unsigned CYC_BSYCS  = cyc_up(longint'(T_BSYCS_NS) * PS_NS);
  localparam int unsigned CYC_CSCN   = cyc_up(longint'(T_CSCN_NS) * PS_NS);
  localparam int unsigned CYC_CSRD   = cyc_up(longint'(T_CSRD_NS) * PS_NS);
  localparam int unsigned CYC_RDCS   = cyc_up(longint'(T_RDCS_NS) * PS_NS);
  localparam int unsigned CYC_RD_HI  = cyc_up(longint'(T_RD_HI_NS) * PS_NS);
  localparam int unsigned CYC_RD_LO  = cyc_up(longint'(T_RDDB_NS) * PS_NS);
  localparam int unsigned CYC_SCLK_H = cyc_up(longint'(T_SCLK_NS) * PS_NS / 64'd2);
  localparam int unsigned CYC_CSCK   = cyc_up(longint'(T_CSCK_NS) * PS_NS);
  localparam int unsigned CYC_CKCS   = cyc_up(longint'(T_CKCS_NS) * PS_NS);
  localparam int unsigned CYC_OS     = cyc_up(longint'(T_OS_NS) * PS_NS);
  localparam int unsigned CYC_GAP    = (CYC_OS > CYC_CSCN) ? CYC_OS : CYC_CSCN;
  localparam int unsigned CYC_CN_PL  = cyc_up(longint'(T_CN_PL_NS) * PS_NS);
  localparam int unsigned CYC_RST_HI = cyc_up(longint'(T_RST_HI_NS) * PS_NS);
  localparam int unsigned CYC_STANDBY_CTRL_N   = cyc_up(longint'(T_STANDBY_CTRL_N_US) * PS_US);
  localparam int unsigned CYC_RSTCN  = cyc_up(longint'(T_RSTCN_US) * PS_US);
  localparam int unsigned CYC_SD_INT = cyc_up(longint'(T_SD_INT_MS) * PS_MS);
  localparam int unsigned CYC_SD_EXT = cyc_up(longint'(T_SD_EXT_MS) * PS_MS);

  // last unit index of one read: words, bytes, serial bits
  localparam logic [6:0] LAST_WORD = 7'h03;
  localparam logic [6:0] LAST_BYTE = 7'h07;
  localparam logic [6:0] LAST_BIT  = 7'h3f;

  typedef enum logic [1:0] {
    RM_WORD   = 2'h0,
    RM_BYTE   = 2'h1,
    RM_SERIAL = 2'h2
  } read_mode_e;

  typedef struct packed {
    logic       conv_start_a;
    logic       conv_start_b;
    logic       cs_n;
    logic       rd_n;
    logic       sclk;
    logic       standby_ctrl_n;
    logic       dev_reset;
    logic [2:0] oversample_select;
  } pin_ctrl_s;

  typedef struct packed {
    logic        valid;
    logic        discard;
    logic        first;
    logic [1:0]  chan;
    logic [15:0] data;
  } sample_s;

  // reset pulse is driven from power-up on
  localparam pin_ctrl_s PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0};

endpackage : adc_host_pkg

// ===== interval_timer.sv
/*
  down counter that flags when a loaded number of cycles has passed.
  assumes an asynchronous active-low reset already released cleanly.
*/
`timescale 1ns/100ps
module interval_timer #(
  parameter int unsigned   W         = 24,
  parameter logic [W-1:0]  RST_COUNT = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);

  logic [W-1:0] cnt_reg;

  // load n: done is seen n-1 cycles later, so the next change lands n edges on
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= RST_COUNT;
    end else if (load_in) begin
      cnt_reg <= count_in;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done_out = (cnt_reg <= {{(W-1){1'b0}}, 1'b1});

endmodule : interval_timer

// ===== adc_host_seq.sv
/*
  host sequencer for a four-channel simultaneous-sampling converter:
  conversion start, word/byte/serial readout, standby and shutdown wake-up.
  assumes busy and data pins are synchronous to mclk_in; one clock domain.
*/
// How it works
// R1: a read during conversion lowers chip select no sooner than 10 ns after conversion start rises.
// R2: a read during conversion ends with chip select high at least 40 ns before busy falls.
// R3: a read after conversion lowers chip select only once busy is seen low.
// R4: chip select is high at least 10 ns before the next conversion start rises.
// R5: chip select falls no later than read strobe, and each strobe phase lasts at least 15 ns.
// R6: the read strobe rises no later than chip select at the end of the access.
// R7: serial reads keep 8 ns setup, 10 ns hold after the last edge and a 50 ns clock period.
// R8: serial clock high and low phases each stay between 45 and 55 percent of the period.
// R9: oversample select is changed only well away from the falling edge of busy.
// R10: conversion start waits 100 us after leaving standby.
// R11: an early start after standby marks the first results to be discarded.
// R12: after shutdown, reset rises 50 ms (internal ref) or 13 ms (external ref) after wake.
// R13: the reset pulse is at least 50 ns, then 25 us pass before conversion start.
// R14: the converter holds busy for the conversion time, 2 us up to 191 us.
// R15: the converter raises busy within 15 ns of conversion start.
// R16: every least delay is rounded up to whole clock cycles.
`timescale 1ns/100ps
module adc_host_seq
  import adc_host_pkg::*;
#(
  parameter int unsigned STANDBY_CTRL_N_CYC   = CYC_STANDBY_CTRL_N,
  parameter int unsigned RSTCN_CYC  = CYC_RSTCN,
  parameter int unsigned SD_INT_CYC = CYC_SD_INT,
  parameter int unsigned SD_EXT_CYC = CYC_SD_EXT
) (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        start_in,
  input  wire read_mode_e  mode_in,
  input  wire logic        during_in,
  input  wire logic [2:0]  osr_in,
  input  wire logic        sleep_in,
  input  wire logic        wake_in,
  input  wire logic        shutdown_in,
  input  wire logic        ext_ref_in,
  input  wire logic        fast_wake_in,
  input  wire logic        busy_in,
  input  wire logic [15:0] parallel_bus_in,
  input  wire logic        serial_out_a_in,
  input  wire logic        first_channel_flag_in,
  output pin_ctrl_s        pins_out,
  output sample_s          sample_out,
  output logic             ready_out
);

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_CONV_LO  = 4'h1,
    S_CONV_HI  = 4'h3,
    S_PRE_RD   = 4'h2,
    S_CS_SETUP = 4'h6,
    S_STB_LO   = 4'h7,
    S_STB_HI   = 4'h5,
    S_CS_HOLD  = 4'h4,
    S_WAIT_BSY = 4'hc,
    S_GAP      = 4'hd,
    S_SLEEP    = 4'hf,
    S_WAKE     = 4'he,
    S_RST_HI   = 4'ha,
    S_RST_WAIT = 4'hb
  } seq_state_e;

  logic        rst_meta_reg;
  logic        rst_n;
  seq_state_e  state_reg;
  seq_state_e  state_next;
  pin_ctrl_s   pins_reg;
  sample_s     sample_reg;
  read_mode_e  mode_reg;
  logic        ready_reg;
  logic        during_reg;
  logic        have_prev_reg;
  logic        shutdown_reg;
  logic        ext_reg;
  logic        disc_now_reg;
  logic [6:0]  unit_reg;
  logic [7:0]  hi_byte_reg;
  logic [14:0] shift_reg;
  logic        seq_load;
  logic [23:0] seq_val;
  logic        seq_done;
  logic        ph_load;
  logic [7:0]  ph_val;
  logic        ph_done;
  logic        ser;
  logic        last;
  logic        conv_go;
  logic        cap;
  logic        cap_emit;
  logic [15:0] cap_word;
  logic [1:0]  cap_chan;
  logic [7:0]  setup_cyc;
  logic [7:0]  lo_cyc;
  logic [7:0]  hi_cyc;
  logic [7:0]  hold_cyc;

  // reset released through two flops
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // long waits; power-up starts inside the reset pulse
  interval_timer #(.W(24), .RST_COUNT(24'(CYC_RST_HI))) u_seq_tmr (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .load_in  (seq_load),
    .count_in (seq_val),
    .done_out (seq_done)
  );

  // strobe and clock phases
  interval_timer #(.W(8), .RST_COUNT(8'h00)) u_ph_tmr (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .load_in  (ph_load),
    .count_in (ph_val),
    .done_out (ph_done)
  );

  // phase lengths per read mode
  assign ser       = (mode_reg == RM_SERIAL);
  assign setup_cyc = ser ? 8'(CYC_CSCK) : 8'(CYC_CSRD);                // R5 R7
  assign lo_cyc    = ser ? 8'(CYC_SCLK_H) : 8'(CYC_RD_LO);             // R5 R8
  assign hi_cyc    = ser ? 8'(CYC_SCLK_H) : 8'(CYC_RD_HI);             // R5 R8
  assign hold_cyc  = ser ? 8'(CYC_CKCS) : 8'(CYC_RDCS);                // R6 R7
  assign last      = (unit_reg == (ser ? LAST_BIT :
                      (mode_reg == RM_BYTE) ? LAST_BYTE : LAST_WORD));
  assign conv_go   = (state_next == S_CONV_LO) && (state_reg != S_CONV_LO);
  assign cap       = (state_reg == S_STB_LO) && ph_done;

  // sequencing and timer loads
  always_comb begin
    state_next = state_reg;
    seq_load   = 1'b0;
    seq_val    = '0;
    ph_load    = 1'b0;
    ph_val     = '0;
    case (state_reg)
      S_IDLE: begin
        if (sleep_in) begin
          state_next = S_SLEEP;
        end else if (start_in) begin
          state_next = S_CONV_LO;
          ph_load    = 1'b1;
          ph_val     = 8'(CYC_CN_PL);
        end
      end
      S_CONV_LO: if (ph_done) begin
        state_next = S_CONV_HI;
        seq_load   = 1'b1;
        seq_val    = 24'(CYC_CNCS);                                    // R1 R16
      end
      S_CONV_HI: if (busy_in) begin                                     // R15
        state_next = during_reg ? S_PRE_RD : S_WAIT_BSY;
      end
      S_PRE_RD: if (seq_done) begin                                     // R1
        state_next = S_CS_SETUP;
        ph_load    = 1'b1;
        ph_val     = setup_cyc;
      end
      S_WAIT_BSY: if (!busy_in) begin                                   // R3
        if (during_reg) begin
          state_next = S_GAP;
          seq_load   = 1'b1;
          seq_val    = 24'(CYC_GAP);                                   // R9
        end else begin
          state_next = S_CS_SETUP;
          ph_load    = 1'b1;
          ph_val     = setup_cyc;
        end
      end
      S_CS_SETUP: if (ph_done) begin                                    // R5 R7
        state_next = S_STB_LO;
        ph_load    = 1'b1;
        ph_val     = lo_cyc;
      end
      S_STB_LO: if (ph_done) begin
        state_next = last ? S_CS_HOLD : S_STB_HI;
        ph_load    = 1'b1;
        ph_val     = last ? hold_cyc : hi_cyc;                         // R6 R7
      end
      S_STB_HI: if (ph_done) begin
        state_next = S_STB_LO;
        ph_load    = 1'b1;
        ph_val     = lo_cyc;
      end
      S_CS_HOLD: if (ph_done) begin
        // a short read ends far inside the 2 us minimum conversion
        state_next = during_reg ? S_WAIT_BSY : S_GAP;                  // R2 R14
        seq_load   = !during_reg;
        seq_val    = 24'(CYC_GAP);                                     // R4
      end
      S_GAP: if (seq_done) state_next = S_IDLE;
      S_SLEEP: if (wake_in) begin
        state_next = S_WAKE;
        seq_load   = 1'b1;
        seq_val    = !shutdown_in ? 24'(STANDBY_CTRL_N_CYC) :
                     ext_ref_in ? 24'(SD_EXT_CYC) : 24'(SD_INT_CYC);   // R10 R12
      end
      S_WAKE: begin
        if (seq_done) begin
          state_next = shutdown_reg ? S_RST_HI : S_IDLE;
          seq_load   = shutdown_reg;
          seq_val    = 24'(CYC_RST_HI);                                // R13
        end else if (!shutdown_reg && fast_wake_in && start_in) begin
          state_next = S_CONV_LO;                                      // R11
          ph_load    = 1'b1;
          ph_val     = 8'(CYC_CN_PL);
        end
      end
      S_RST_HI: if (seq_done) begin
        state_next = S_RST_WAIT;
        seq_load   = 1'b1;
        seq_val    = 24'(RSTCN_CYC);                                   // R13
      end
      S_RST_WAIT: if (seq_done) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) state_reg <= S_RST_HI;
    else        state_reg <= state_next;
  end

  // pins follow the next state so each edge lands with the transition
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pins_reg <= PINS_RST;
    end else begin
      pins_reg.conv_start_a   <= (state_next != S_CONV_LO);
      pins_reg.conv_start_b   <= (state_next != S_CONV_LO);
      pins_reg.cs_n           <= !(state_next inside {S_CS_SETUP, S_STB_LO, S_STB_HI, S_CS_HOLD});
      pins_reg.rd_n           <= !((state_next == S_STB_LO) && !ser);      // R5
      pins_reg.sclk           <= !((state_next == S_STB_LO) && ser);       // R7
      pins_reg.standby_ctrl_n <= (state_next != S_SLEEP);
      pins_reg.dev_reset      <= (state_next == S_RST_HI);
      if (conv_go) pins_reg.oversample_select <= osr_in;                   // R9
    end
  end

  // per-conversion settings; serial is too slow to read inside a conversion
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg      <= RM_WORD;
      during_reg    <= 1'b0;
      disc_now_reg  <= 1'b0;
      have_prev_reg <= 1'b0;
      shutdown_reg  <= 1'b0;
      ext_reg       <= 1'b0;
    end else begin
      if (conv_go) begin
        mode_reg     <= mode_in;
        during_reg   <= during_in && (mode_in != RM_SERIAL) && have_prev_reg &&
                        (state_reg != S_WAKE);
        disc_now_reg <= (state_reg == S_WAKE);                          // R11
      end
      if (state_reg == S_GAP) have_prev_reg <= 1'b1;
      if (state_reg == S_SLEEP) have_prev_reg <= 1'b0;
      if (state_next == S_WAKE && state_reg == S_SLEEP) begin
        shutdown_reg <= shutdown_in;
        ext_reg      <= ext_ref_in;
      end
    end
  end

  // unit counter: word, byte or bit within one read
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n)                    unit_reg <= 7'h00;
    else if (state_reg == S_CS_SETUP) unit_reg <= 7'h00;
    else if (cap)                  unit_reg <= unit_reg + 7'h01;
  end

  // assemble a word; byte mode sends the high byte first
  always_comb begin
    cap_word = parallel_bus_in;
    cap_chan = unit_reg[1:0];
    cap_emit = 1'b1;
    if (mode_reg == RM_BYTE) begin
      cap_word = {hi_byte_reg, parallel_bus_in[7:0]};
      cap_chan = unit_reg[2:1];
      cap_emit = unit_reg[0];
    end else if (ser) begin
      cap_word = {shift_reg, serial_out_a_in};
      cap_chan = unit_reg[5:4];
      cap_emit = (unit_reg[3:0] == 4'hf);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      hi_byte_reg <= 8'h00;
      shift_reg   <= 15'h0000;
    end else if (cap) begin
      hi_byte_reg <= parallel_bus_in[7:0];
      shift_reg   <= {shift_reg[13:0], serial_out_a_in};
    end
  end

  // one-cycle result strobe, sampled on the strobe's rising edge
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= '0;
      ready_reg  <= 1'b0;
    end else begin
      sample_reg.valid <= cap && cap_emit;
      if (cap && cap_emit) begin
        sample_reg.discard <= disc_now_reg;
        sample_reg.first   <= first_channel_flag_in;
        sample_reg.chan    <= cap_chan;
        sample_reg.data    <= cap_word;
      end
      ready_reg <= (state_next == S_IDLE);
    end
  end

  assign pins_out   = pins_reg;
  assign sample_out = sample_reg;
  assign ready_out  = ready_reg;

  // checking helpers: how long each pin level has lasted
  logic [31:0] conv_hi_cnt;
  logic [31:0] cs_hi_cnt;
  logic [31:0] busy_lo_cnt;
  logic [31:0] standby_ctrl_n_hi_cnt;
  logic [31:0] rst_hi_cnt;
  logic [31:0] rst_lo_cnt;

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hffffffff) ? v : v + 32'h1;
  endfunction : sat_inc

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      conv_hi_cnt <= 32'hffffffff;
      cs_hi_cnt   <= 32'hffffffff;
      busy_lo_cnt <= 32'h0;
      standby_ctrl_n_hi_cnt <= 32'hffffffff;
      rst_hi_cnt  <= 32'h0;
      rst_lo_cnt  <= 32'h0;
    end else begin
      conv_hi_cnt <= pins_reg.conv_start_a ? sat_inc(conv_hi_cnt) : 32'h0;
      cs_hi_cnt   <= pins_reg.cs_n ? sat_inc(cs_hi_cnt) : 32'h0;
      busy_lo_cnt <= !busy_in ? sat_inc(busy_lo_cnt) : 32'h0;
      standby_ctrl_n_hi_cnt <= pins_reg.standby_ctrl_n ? sat_inc(standby_ctrl_n_hi_cnt) : 32'h0;
      rst_hi_cnt  <= pins_reg.dev_reset ? sat_inc(rst_hi_cnt) : 32'h0;
      rst_lo_cnt  <= !pins_reg.dev_reset ? sat_inc(rst_lo_cnt) : 32'h0;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  sequence s_rd_low;
    (!pins_reg.cs_n && !pins_reg.rd_n) [*4] ##1 pins_reg.rd_n;
  endsequence
  sequence s_sclk_period;
    (!pins_reg.sclk) [*5] ##1 pins_reg.sclk [*5];
  endsequence

  property p_cs_after_conv;
    $fell(pins_reg.cs_n) && during_reg |-> conv_hi_cnt >= CYC_CNCS;
  endproperty
  a_cs_after_conv: assert property (p_cs_after_conv)   // R1
    else $error("chip select fell too soon after conversion start");

  property p_cs_before_busy;
    $fell(busy_in) && during_reg |-> pins_reg.cs_n && cs_hi_cnt >= CYC_CSBSY;
  endproperty
  a_cs_before_busy: assert property (p_cs_before_busy) // R2
    else $error("in-conversion read ended too close to busy fall");

  property p_cs_after_busy;
    $fell(pins_reg.cs_n) && !during_reg |-> !$past(busy_in);
  endproperty
  a_cs_after_busy: assert property (p_cs_after_busy)   // R3
    else $error("chip select fell while busy was high");

  property p_cs_before_conv;
    $rose(pins_reg.conv_start_a) |-> cs_hi_cnt >= CYC_CSCN;
  endproperty
  a_cs_before_conv: assert property (p_cs_before_conv) // R4
    else $error("conversion started too soon after chip select rose");

  property p_rd_low;
    $fell(pins_reg.rd_n) |-> s_rd_low;
  endproperty
  a_rd_low: assert property (p_rd_low)                 // R5
    else $error("read strobe low phase wrong or outside chip select");

  property p_rd_high;
    $rose(pins_reg.rd_n) |-> pins_reg.rd_n [*3];
  endproperty
  a_rd_high: assert property (p_rd_high)               // R5
    else $error("read strobe high phase too short");

  property p_rd_before_cs;
    $rose(pins_reg.cs_n) |-> $past(pins_reg.rd_n) && $past(pins_reg.sclk);
  endproperty
  a_rd_before_cs: assert property (p_rd_before_cs)     // R6
    else $error("chip select rose before the strobe");

  property p_sclk_setup;
    $fell(pins_reg.cs_n) && ser |-> pins_reg.sclk [*2] ##1 !pins_reg.sclk;
  endproperty
  a_sclk_setup: assert property (p_sclk_setup)         // R7
    else $error("serial clock setup after chip select wrong");

  property p_sclk_period;
    $fell(pins_reg.sclk) |-> s_sclk_period;
  endproperty
  a_sclk_period: assert property (p_sclk_period)       // R8
    else $error("serial clock phase not half the period");

  property p_osr_stable;
    $changed(pins_reg.oversample_select) |-> !busy_in && busy_lo_cnt >= CYC_OS;
  endproperty
  a_osr_stable: assert property (p_osr_stable)         // R9
    else $error("oversample select changed near busy fall");

  property p_standby_ctrl_n_wait;
    $rose(pins_reg.conv_start_a) && !disc_now_reg |-> standby_ctrl_n_hi_cnt >= STANDBY_CTRL_N_CYC;
  endproperty
  a_standby_ctrl_n_wait: assert property (p_standby_ctrl_n_wait)           // R10
    else $error("conversion started too soon after standby exit");

  property p_sd_wait;
    $rose(pins_reg.dev_reset) |-> standby_ctrl_n_hi_cnt >= (ext_reg ? SD_EXT_CYC : SD_INT_CYC);
  endproperty
  a_sd_wait: assert property (p_sd_wait)               // R12
    else $error("reset raised too soon after shutdown exit");

  property p_rst_pulse;
    $fell(pins_reg.dev_reset) |-> rst_hi_cnt >= CYC_RST_HI;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)           // R13
    else $error("reset pulse too short");

  property p_rst_to_conv;
    $rose(pins_reg.conv_start_a) |-> rst_lo_cnt >= RSTCN_CYC;
  endproperty
  a_rst_to_conv: assert property (p_rst_to_conv)       // R13
    else $error("conversion started too soon after reset");

endmodule : adc_host_seq

// ===== adc_dev_model.sv
/*
  behavioural converter: busy timer and word, byte or serial data out.
  assumes host pins change just after mclk edges; mode comes from the bench.
*/
`timescale 1ns/100ps
module adc_dev_model
  import adc_host_pkg::*;
#(
  parameter int unsigned BUSY_CYC = 400 // 2 us, oversampling not modelled
) (
  input  wire logic       clk_in,
  input  wire read_mode_e mode_in,
  input  wire pin_ctrl_s  pins_in,
  output logic            busy_out,
  output logic [15:0]     bus_out,
  output logic            sdo_out,
  output logic            first_out
);
  pin_ctrl_s   last_reg = PINS_RST;
  int unsigned cnt_reg  = 0;
  logic [6:0]  unit_reg = '0;
  logic        junk_reg = 1'b0;
  logic [1:0]  chan;
  logic [15:0] word;
  // busy one cycle after the start edge, then the conversion time
  always_ff @(posedge clk_in) begin
    last_reg <= pins_in;
    junk_reg <= ~junk_reg;
    if (pins_in.conv_start_a && !last_reg.conv_start_a) cnt_reg <= BUSY_CYC;
    else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
    if (pins_in.cs_n) unit_reg <= '0;
    else if ((pins_in.rd_n && !last_reg.rd_n) || (pins_in.sclk && !last_reg.sclk))
      unit_reg <= unit_reg + 7'h01;
  end
  // released lines toggle every cycle so stale data never passes
  assign busy_out  = (cnt_reg != 0);
  assign chan      = (mode_in == RM_SERIAL) ? unit_reg[5:4] :
                     (mode_in == RM_BYTE) ? unit_reg[2:1] : unit_reg[1:0];
  assign word      = {2'h2, chan, 12'h5a3};
  assign bus_out   = pins_in.cs_n ? {16{junk_reg}} : (mode_in != RM_BYTE) ? word :
                     {{8{junk_reg}}, unit_reg[0] ? word[7:0] : word[15:8]};
  assign sdo_out   = pins_in.cs_n ? junk_reg : word[4'hf - unit_reg[3:0]];
  assign first_out = pins_in.cs_n ? junk_reg : (chan == 2'h0);
endmodule : adc_dev_model

// ===== testbench.sv
/*
  self-checking bench: host sequencer against the device model.
  assumes shortened wake-up counts; every expectation follows them.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
  import adc_host_pkg::*;
  localparam int unsigned STANDBY_CTRL_N = 40;
  localparam int unsigned RSTCN = 20;
  logic       mclk_in = 0, nrst_in = 0, start = 0, during = 0, sleep = 0, wake = 0;
  logic       shut = 0, ext = 0, fast = 0, busy, sdo, first, ready, bprev = 0;
  logic [2:0] osr = '0;
  logic [15:0] bus;
  read_mode_e mode = RM_WORD;
  pin_ctrl_s  pins, prev = PINS_RST;
  sample_s    smp;
  int         bad_count = 0, checks = 0, s_cs = 0, s_cn = 0, s_sb = 99999, s_rs = 0;
  int         s_rh = 0, s_rd = 0, s_ck = 0;
  always #2.5 mclk_in = ~mclk_in;
  adc_host_seq #(.STANDBY_CTRL_N_CYC(STANDBY_CTRL_N), .RSTCN_CYC(RSTCN), .SD_INT_CYC(60), .SD_EXT_CYC(30))
    adc_host_seq_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .start_in(start), .mode_in(mode),
    .during_in(during), .osr_in(osr), .sleep_in(sleep), .wake_in(wake), .shutdown_in(shut),
    .ext_ref_in(ext), .fast_wake_in(fast), .busy_in(busy), .parallel_bus_in(bus),
    .serial_out_a_in(sdo), .first_channel_flag_in(first), .pins_out(pins),
    .sample_out(smp), .ready_out(ready));
  adc_dev_model adc_dev_model_i (.clk_in(mclk_in), .mode_in(mode), .pins_in(pins),
    .busy_out(busy), .bus_out(bus), .sdo_out(sdo), .first_out(first));
  // pin timing watch; each counter holds cycles since its edge
  always @(negedge mclk_in) begin
    if (!pins.rd_n || !pins.sclk) `CHK("strobe in cs", 1'b0, pins.cs_n)
    `CHK("conv b", pins.conv_start_a, pins.conv_start_b)
    if (!pins.cs_n && prev.cs_n && busy) `CHK("cs fall", 1'b1, during && s_cn >= CYC_CNCS)
    if (bprev && !busy) `CHK("cs before busy", 1'b1, s_cs >= CYC_CSBSY)
    if (pins.rd_n !== prev.rd_n) `CHK("rd phase", 1'b1, s_rd >= CYC_RD_HI)
    if (pins.sclk && !prev.sclk) `CHK("sclk low", 1'b1, s_ck == CYC_SCLK_H)
    if (!pins.sclk && prev.sclk) `CHK("sclk setup", 1'b1, s_ck >= CYC_CSCK)
    if (!pins.dev_reset && prev.dev_reset) `CHK("rst pulse", 1'b1, s_rh >= CYC_RST_HI)
    if (pins.conv_start_a && !prev.conv_start_a) begin
      `CHK("cs to conv", 1'b1, s_cs >= CYC_CSCN)
      `CHK("standby_ctrl_n to conv", 1'b1, fast || s_sb >= STANDBY_CTRL_N)
      `CHK("rst to conv", 1'b1, s_rs >= RSTCN)
    end
    s_cs = pins.cs_n ? s_cs + 1 : 0;
    s_sb = pins.standby_ctrl_n ? s_sb + 1 : 0;
    s_rs = pins.dev_reset ? 0 : s_rs + 1;
    s_rh = pins.dev_reset ? s_rh + 1 : 0;
    s_cn = (pins.conv_start_a && !prev.conv_start_a) ? 1 : s_cn + 1;
    s_rd = (pins.rd_n !== prev.rd_n) ? 1 : s_rd + 1;
    s_ck = (pins.sclk !== prev.sclk || pins.cs_n !== prev.cs_n) ? 1 : s_ck + 1;
    prev = pins;
    bprev = busy;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic wait_ready(output int n);
    for (n = 0; ready !== 1'b1; n++) begin
      @(negedge mclk_in);
      if (n > 20000) begin `CHK("ready", 1'b1, ready) close_out(); end
    end
  endtask : wait_ready
  // one conversion, four samples checked against the model pattern
  task automatic conv_read(input read_mode_e m, input logic dur, input logic disc);
    int w;
    @(posedge mclk_in);
    mode <= m;
    during <= dur;
    osr <= {1'b0, m};
    start <= 1'b1;
    repeat (disc ? 3 : 1) @(posedge mclk_in);
    start <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      for (w = 0; smp.valid !== 1'b1; w++) begin
        @(negedge mclk_in);
        if (w > 3000) begin `CHK("valid", 1'b1, smp.valid) close_out(); end
      end
      `CHK("data", {2'h2, k[1:0], 12'h5a3}, smp.data)
      `CHK("chan", k[1:0], smp.chan)
      `CHK("first", k == 0, smp.first)
      `CHK("discard", disc, smp.discard)
      @(negedge mclk_in);
    end
    `CHK("osr pins", osr, pins.oversample_select)
    $display("read mode %0d during %0d done", m, dur);
  endtask : conv_read
  // sleep, then wake from standby or shutdown, optionally starting early
  task automatic power(input logic sd, input logic er, input logic fw);
    int n;
    wait_ready(n);
    @(posedge mclk_in);
    sleep <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sleep <= 1'b0;
    @(negedge mclk_in);
    `CHK("standby", 1'b0, pins.standby_ctrl_n)
    @(posedge mclk_in);
    {shut, ext, fast, wake} <= {sd, er, fw, 1'b1};
    if (fw) conv_read(RM_WORD, 1'b0, 1'b1);
    for (n = 0; sd && pins.dev_reset !== 1'b1 && n < 999; n++) @(negedge mclk_in);
    if (sd) `CHK("shutdown wait", 1'b1, n >= (er ? 30 : 60) && n < 999)
    wait_ready(n);
    @(posedge mclk_in);
    {wake, fast} <= 2'h0;
    if (!sd && !fw) `CHK("standby wait", 1'b1, n >= STANDBY_CTRL_N - 1)
    conv_read(RM_SERIAL, 1'b0, 1'b0);
    $display("wake shutdown %0d ext %0d fast %0d done", sd, er, fw);
  endtask : power
  initial begin
    int n;
    repeat (3) @(posedge mclk_in);
    `CHK("reset pulse", 1'b1, pins.dev_reset)
    nrst_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wait_ready(n);
      conv_read(read_mode_e'(i % 3), i > 2, 1'b0);
    end
    power(1'b0, 1'b0, 1'b0);
    power(1'b1, 1'b1, 1'b0);
    power(1'b1, 1'b0, 1'b0);
    power(1'b0, 1'b0, 1'b1);
    close_out();
  end
endmodule : testbench
